//--- dv/rtc_cal_charge_bench.sv
// self-checking bench for the calibration and backup charge block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cal_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module rtc_cal_charge_bench;
    import rtc_cal_pkg::*;
    // osc at 2 core cycles, the fastest the synchroniser resolves, so one second fits the run
    localparam int OSC_PER = 2;
    logic       clk   = 1'b0;
    logic       srst  = 1'b1;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       aflag = 1'b0;
    logic       alen  = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic       pin;
    logic       oe;
    logic       chg;
    logic       fast;
    logic       tick;
    wire        osc;
    wire        at_main;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         rises[4] = '{32768, 64, 8, 1};

    rtc_cal_charge #(.CORR_WINDOW_S(2)) rtc_cal_charge_i (
        .core_clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .osc_32k_i(osc),
        .alarm_flag_i(aflag), .alarm_flag_enable_i(alen), .backup_at_main_i(at_main),
        .alarm_clock_output_o(pin), .alarm_clock_output_oe_o(oe),
        .charge_on_o(chg), .charge_fast_o(fast), .sec_tick_o(tick)
    );

    rtc_cal_far_side #(.OSC_HALF_NS(OSC_PER * 25 / 2), .CHARGE_CYCLES(200)) rtc_cal_far_side_i (
        .core_clk_i(clk), .charge_on_i(chg), .osc_32k_o(osc), .backup_at_main_o(at_main)
    );

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the read edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask

    task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        `CHK(nm, e, v)
    endtask

    task automatic edge_to(input logic v, inout int n);
        while (pin !== v && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic period(input string nm, input int e);
        int n;
        n = 0;
        edge_to(1'b0, n);
        edge_to(1'b1, n);
        n = 0;
        edge_to(1'b0, n);
        edge_to(1'b1, n);
        `CHK(nm, e, n)
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(25 * 80000);
        fail_count++;
        $display("test watchdog expired");
        results();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        `CHK("oe reset", 1'b0, oe)
        srst <= 1'b0;
        chk_reg("ctrl", `ADDR_CONTROL_FLAGS, 8'h00);
        chk_reg("comp", `ADDR_COMPANION_CTRL, `COMP_RESET);
        chk_reg("corr", `ADDR_CLOCK_CORR, {2'b00, `CORR_RESET});
        chk_reg("unmapped", 8'h7F, 8'h00);
        `CHK("oe", 1'b1, oe)
        $display("test reset done");

        wr_reg(`ADDR_CLOCK_CORR, 8'h25);
        chk_reg("corr locked", `ADDR_CLOCK_CORR, 8'h00);
        wr_reg(`ADDR_CONTROL_FLAGS, 8'h04);
        wr_reg(`ADDR_CLOCK_CORR, 8'hFF);
        chk_reg("ctrl cal", `ADDR_CONTROL_FLAGS, 8'h04);
        chk_reg("corr max", `ADDR_CLOCK_CORR, 8'h3F);
        wr_reg(`ADDR_CLOCK_CORR, 8'h21);
        chk_reg("corr open", `ADDR_CLOCK_CORR, 8'h21);
        $display("test correction access done");

        // alarm asked for and correction set, yet the tap must stay plain
        aflag <= 1'b1;
        alen  <= 1'b1;
        wr_reg(`ADDR_COMPANION_CTRL, 8'h40);
        period("cal wave", 64 * OSC_PER);
        `CHK("cal oe", 1'b1, oe)
        wr_reg(`ADDR_CONTROL_FLAGS, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("alarm high", 1'b1, pin)
        aflag <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("alarm low", 1'b0, pin)
        alen <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("float", 1'b0, oe)
        $display("test pin select done");

        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`ADDR_COMPANION_CTRL, {2'b00, c[1:0], 4'h0});
            repeat (3) @(posedge clk);
            `CHK("wave oe", 1'b1, oe)
            if (c > 0)
                period("wave", rises[c] * OSC_PER);
        end
        $display("test wave select done");

        wr_reg(`ADDR_COMPANION_CTRL, 8'h08);
        repeat (6) @(posedge clk);
        `CHK("charge", 1'b1, chg)
        `CHK("fast off", 1'b0, fast)
        rd_reg(`ADDR_CAL_STATUS, d);
        `CHK("stat charge", 1'b1, d[`STAT_CHARGING_BIT])
        wr_reg(`ADDR_COMPANION_CTRL, 8'h0C);
        repeat (6) @(posedge clk);
        `CHK("fast on", 1'b1, fast)
        for (int n = 0; n < 400 && chg !== 1'b0; n++)
            @(posedge clk);
        `CHK("charge end", 1'b0, chg)
        `CHK("fast end", 1'b0, fast)
        wr_reg(`ADDR_COMPANION_CTRL, 8'h00);
        $display("test charge done");

        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // counters restart and no magnitude is loaded before a window end: first second is plain
        for (cyc = 0; cyc < 70000 && tick !== 1'b1; cyc++)
            @(posedge clk);
        `CHK("second len", 1'b1, cyc >= 32768 * OSC_PER && cyc <= 32768 * OSC_PER + 8)
        @(posedge clk);
        `CHK("tick width", 1'b0, tick)
        chk_reg("corr kept", `ADDR_CLOCK_CORR, 8'h21);
        chk_reg("ctrl cleared", `ADDR_CONTROL_FLAGS, 8'h00);
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire

//--- dv/rtc_cal_far_side.sv
// far side model: scaled crystal source and backup capacitor with level sense
`timescale 1ns/1ps
`default_nettype none
module rtc_cal_far_side #(
    parameter int OSC_HALF_NS   = 50,
    parameter int CHARGE_CYCLES = 200
)
(
    input  wire logic core_clk_i,       // core clock
    input  wire logic charge_on_i,      // trickle source on
    output var  logic osc_32k_o,        // scaled timebase
    output wire logic backup_at_main_o  // capacitor at main level
);
    int fill_q = 0;

    // crystal runs free, phase offset from the core clock on purpose
    initial
    begin
        osc_32k_o = 1'b0;
        #7;
        forever #(OSC_HALF_NS) osc_32k_o = ~osc_32k_o;
    end

    // capacitor fills only while sourced and keeps its charge after
    always_ff @(posedge core_clk_i)
    begin
        if (charge_on_i && fill_q < CHARGE_CYCLES)
        begin
            fill_q <= fill_q + 1;
        end
    end

    assign backup_at_main_o = (fill_q >= CHARGE_CYCLES);
endmodule
`default_nettype wire

//--- logic/rtc_cal_charge.sv
// calibration mode, digital timebase correction, output pin select and trickle charge control
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cal_defines.svh"
// Function
// R1: backup charge enable sources trickle current until backup pin reaches main supply.
// R2: fast charge enable raises the trickle current to the high level.
// R3: host keeps backup charge off when no backup supply is fitted.
// R4: host keeps backup charge off when a lithium battery backs the clock.
// R5: writing the calibration-mode bit enters or leaves calibration mode.
// R6: in calibration mode the output pin carries 512 Hz, never the alarm.
// R7: timekeeping is corrected from stored sign and five-bit magnitude.
// R8: fast oscillator removes timebase pulses, slow oscillator adds them.
// R9: sign one adds pulses, sign zero removes pulses.
// R10: six-bit code, sign in top bit, magnitude in lower five bits.
// R11: pulses are added or removed after the 512 Hz tap.
// R12: correction setting survives loss of all supplies.
// R13: correction bits accept writes only while calibration mode is on.
// R14: leaving calibration mode returns the pin to its selected function.
// R15: alarm, square wave or float per alarm enable and alarm select.
// R16: two frequency bits choose 1, 512, 4096 or 32768 Hz.
// R17: zero magnitude leaves the timebase unaltered whatever the sign.
module rtc_cal_charge
    import rtc_cal_pkg::*;
#(
    parameter int CORR_WINDOW_S = `CORR_WINDOW_S
)
(
    input  wire logic       core_clk_i,          // 40 MHz core clock
    input  wire logic       srst_i,              // synchronous reset, high
    input  wire logic [7:0] reg_addr_i,          // register address
    input  wire logic [7:0] reg_wdata_i,         // register write data
    input  wire logic       reg_wr_i,            // write strobe
    input  wire logic       reg_rd_i,            // read strobe
    output logic      [7:0] reg_rdata_o,         // read data, cycle after strobe
    input  wire logic       osc_32k_i,           // 32.768 kHz timebase pin
    input  wire logic       alarm_flag_i,        // alarm flag from alarm logic
    input  wire logic       alarm_flag_enable_i, // alarm enable setting
    input  wire logic       backup_at_main_i,    // comparator: backup pin at main level
    output logic            alarm_clock_output_o,    // output pin level
    output logic            alarm_clock_output_oe_o, // output pin drive enable
    output logic            charge_on_o,         // trickle source on
    output logic            charge_fast_o,       // high current select
    output logic            sec_tick_o           // corrected one-second pulse
);
    import rtc_cal_pkg::*;

    localparam int WIN_W = $clog2(CORR_WINDOW_S + 1);

    logic             cal_q;
    logic [5:0]       corr_q = `CORR_RESET;
    logic [7:0]       comp_q;
    logic [7:0]       rdata_q;
    logic             osc_s1_q;
    logic             osc_s2_q;
    logic             osc_s3_q;
    logic             main_s1_q;
    logic             main_s2_q;
    logic [5:0]       pre_q;
    logic [9:0]       sub_q;
    logic [WIN_W-1:0] win_q;
    logic [4:0]       left_q;
    logic             pin_q;
    logic             pin_oe_q;
    logic             charge_q;
    logic             fast_q;
    logic             tick_q;
    logic             osc_rise;
    logic             tick512;
    logic [9:0]       sec_limit;
    logic             sec_end;
    logic             wave;
    out_mode_type     mode;
    wave_sel_type     wsel;

    function automatic logic [9:0] limit_of(input logic sign, input logic [4:0] left);
        limit_of = (left == 5'h00) ? `SEC_LIMIT_NOMINAL            // R17
                 : sign            ? `SEC_LIMIT_NOMINAL - 10'h001  // R9
                 :                   `SEC_LIMIT_NOMINAL + 10'h001; // R9
    endfunction

    // register writes
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            cal_q <= 1'b0;
        end
        else if (reg_wr_i && reg_addr_i == `ADDR_CONTROL_FLAGS)
        begin
            cal_q <= reg_wdata_i[`CTRL_CAL_BIT]; // R5
        end
    end

    // nonvolatile: kept across srst, only power-on initial value
    always_ff @(posedge core_clk_i)
    begin
        if (reg_wr_i && reg_addr_i == `ADDR_CLOCK_CORR && cal_q) // R13 R12
        begin
            corr_q <= reg_wdata_i[`CORR_SIGN_BIT:0]; // R10
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            comp_q <= `COMP_RESET;
        end
        else if (reg_wr_i && reg_addr_i == `ADDR_COMPANION_CTRL)
        begin
            comp_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !reg_rd_i)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            unique case (reg_addr_i)
                `ADDR_CONTROL_FLAGS:  rdata_q <= {5'h00, cal_q, 2'h0};
                `ADDR_CLOCK_CORR:     rdata_q <= {2'h0, corr_q};
                `ADDR_COMPANION_CTRL: rdata_q <= comp_q;
                `ADDR_CAL_STATUS:     rdata_q <= {6'h00, wave_sec(sub_q), charge_q};
                default:              rdata_q <= 8'h00;
            endcase
        end
    end

    function automatic logic wave_sec(input logic [9:0] cnt);
        wave_sec = (cnt < 10'h100);
    endfunction

    // pin synchronisers; first stage read only by the second
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            osc_s1_q  <= 1'b0;
            osc_s2_q  <= 1'b0;
            osc_s3_q  <= 1'b0;
            main_s1_q <= 1'b0;
            main_s2_q <= 1'b0;
        end
        else
        begin
            osc_s1_q  <= osc_32k_i;
            osc_s2_q  <= osc_s1_q;
            osc_s3_q  <= osc_s2_q;
            main_s1_q <= backup_at_main_i;
            main_s2_q <= main_s1_q;
        end
    end

    assign osc_rise = osc_s2_q && !osc_s3_q;
    assign tick512  = osc_rise && pre_q == `PRE_MAX;

    // prescaler up to the 512 Hz tap: never touched by correction
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            pre_q <= 6'h00;
        end
        else if (osc_rise)
        begin
            pre_q <= pre_q + 6'h01; // R11
        end
    end

    // correction lives in the 512 Hz to 1 Hz stage, one pulse per second at most
    assign sec_limit = limit_of(corr_q[`CORR_SIGN_BIT], left_q); // R7
    assign sec_end   = tick512 && sub_q >= sec_limit;

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            sub_q <= 10'h000;
        end
        else if (sec_end)
        begin
            sub_q <= 10'h000; // R8 R11
        end
        else if (tick512)
        begin
            sub_q <= sub_q + 10'h001;
        end
    end

    // window of seconds; magnitude reloaded at each window end
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            win_q  <= '0;
            left_q <= 5'h00;
        end
        else if (sec_end)
        begin
            if (win_q == WIN_W'(CORR_WINDOW_S - 1))
            begin
                win_q  <= '0;
                left_q <= corr_q[`CORR_MAG_HI:0]; // R7
            end
            else
            begin
                win_q <= win_q + WIN_W'(1);
                if (left_q != 5'h00)
                begin
                    left_q <= left_q - 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= sec_end;
        end
    end

    // output pin function
    assign wsel = wave_sel_type'({comp_q[`COMP_FREQ_HI_BIT], comp_q[`COMP_FREQ_LO_BIT]});

    assign mode = cal_q                  ? OUT_CAL   : // R6
                  !comp_q[`COMP_SEL_BIT] ? OUT_WAVE  : // R14 R15
                  alarm_flag_enable_i    ? OUT_ALARM : // R15
                                           OUT_FLOAT;  // R15

    always_comb
    begin
        unique case (wsel)
            WAVE_1HZ:   wave = wave_sec(sub_q); // R16
            WAVE_512HZ: wave = pre_q[5];
            WAVE_4KHZ:  wave = pre_q[2];
            WAVE_32KHZ: wave = osc_s2_q;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            unique case (mode)
                OUT_CAL:
                begin
                    pin_q    <= pre_q[5]; // R6
                    pin_oe_q <= 1'b1;
                end
                OUT_ALARM:
                begin
                    pin_q    <= alarm_flag_i;
                    pin_oe_q <= 1'b1;
                end
                OUT_WAVE:
                begin
                    pin_q    <= wave; // R16
                    pin_oe_q <= 1'b1;
                end
                OUT_FLOAT:
                begin
                    pin_q    <= 1'b0;
                    pin_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // trickle charger
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            charge_q <= 1'b0;
            fast_q   <= 1'b0;
        end
        else
        begin
            charge_q <= comp_q[`COMP_CHARGE_BIT] && !main_s2_q; // R1
            fast_q   <= comp_q[`COMP_CHARGE_BIT] && !main_s2_q && comp_q[`COMP_FAST_BIT]; // R2
        end
    end

    assign reg_rdata_o             = rdata_q;
    assign alarm_clock_output_o    = pin_q;
    assign alarm_clock_output_oe_o = pin_oe_q;
    assign charge_on_o             = charge_q;
    assign charge_fast_o           = fast_q;
    assign sec_tick_o              = tick_q;

    // checks
    property p_charge_on;
        @(posedge core_clk_i) disable iff (srst_i)
        charge_on_o |-> $past(comp_q[`COMP_CHARGE_BIT]) && !$past(main_s2_q);
    endproperty
    a_charge_on: assert property (p_charge_on) else $error("charge on without enable"); // R1
    property p_fast;
        @(posedge core_clk_i) disable iff (srst_i)
        charge_fast_o |-> charge_on_o && $past(comp_q[`COMP_FAST_BIT]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast charge without base charge"); // R2
    property p_cal_write;
        @(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && reg_addr_i == `ADDR_CONTROL_FLAGS |=> cal_q == $past(reg_wdata_i[2]);
    endproperty
    a_cal_write: assert property (p_cal_write) else $error("cal bit not written"); // R5
    property p_cal_pin;
        @(posedge core_clk_i) disable iff (srst_i)
        cal_q |=> alarm_clock_output_oe_o && alarm_clock_output_o == $past(pre_q[5]);
    endproperty
    a_cal_pin: assert property (p_cal_pin) else $error("pin not 512 Hz in cal mode"); // R6
    property p_corr_lock;
        @(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && !cal_q |=> $stable(corr_q);
    endproperty
    a_corr_lock: assert property (p_corr_lock) else $error("correction written outside cal"); // R13
    property p_pre_free;
        @(posedge core_clk_i) disable iff (srst_i)
        osc_rise |=> pre_q == $past(pre_q) + 6'h01;
    endproperty
    a_pre_free: assert property (p_pre_free) else $error("512 Hz tap disturbed"); // R11
    property p_zero_mag;
        @(posedge core_clk_i) disable iff (srst_i)
        sec_end && left_q == 5'h00 |-> sub_q == 10'h1FF;
    endproperty
    a_zero_mag: assert property (p_zero_mag) else $error("second altered at zero magnitude"); // R17
    property p_sign;
        @(posedge core_clk_i) disable iff (srst_i)
        sec_end && left_q != 5'h00 |-> sub_q == (corr_q[5] ? 10'h1FE : 10'h200);
    endproperty
    a_sign: assert property (p_sign) else $error("wrong correction direction"); // R9
    property p_alarm_pin;
        @(posedge core_clk_i) disable iff (srst_i)
        !cal_q && comp_q[6] && alarm_flag_enable_i
            |=> alarm_clock_output_oe_o && alarm_clock_output_o == $past(alarm_flag_i);
    endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm not on pin"); // R15
    property p_float;
        @(posedge core_clk_i) disable iff (srst_i)
        !cal_q && comp_q[6] && !alarm_flag_enable_i |=> !alarm_clock_output_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("pin driven when it should float"); // R15

    c_cal_enter: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(cal_q));
    c_corr_add:  cover property (@(posedge core_clk_i) disable iff (srst_i)
        sec_end && left_q != 5'h00 && corr_q[5]);
    c_fast:      cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(charge_fast_o));
endmodule
`default_nettype wire

//--- logic/rtc_cal_defines.svh
// offsets, field positions, reset values and timing counts of the calibration block
`ifndef RTC_CAL_DEFINES_SVH
`define RTC_CAL_DEFINES_SVH
`define ADDR_CONTROL_FLAGS   8'h00
`define ADDR_CLOCK_CORR      8'h01
`define ADDR_COMPANION_CTRL  8'h18
`define ADDR_CAL_STATUS      8'h20
`define CTRL_CAL_BIT         2
`define CORR_SIGN_BIT        5
`define CORR_MAG_HI          4
`define COMP_SEL_BIT         6
`define COMP_FREQ_HI_BIT     5
`define COMP_FREQ_LO_BIT     4
`define COMP_CHARGE_BIT      3
`define COMP_FAST_BIT        2
`define STAT_CHARGING_BIT    0
`define STAT_SEC_WAVE_BIT    1
`define CORR_RESET           6'h00
`define COMP_RESET           8'h00
`define PRE_MAX              6'h3F
`define SEC_LIMIT_NOMINAL    10'h1FF
`define CORR_WINDOW_S        450
`endif

//--- logic/rtc_cal_pkg.sv
// types shared by the calibration and backup charge block
package rtc_cal_pkg;
    typedef enum logic [3:0] {
        OUT_CAL   = 4'b0001,
        OUT_ALARM = 4'b0010,
        OUT_WAVE  = 4'b0100,
        OUT_FLOAT = 4'b1000
    } out_mode_type;
    typedef enum logic [1:0] {
        WAVE_1HZ   = 2'h0,
        WAVE_512HZ = 2'h1,
        WAVE_4KHZ  = 2'h2,
        WAVE_32KHZ = 2'h3
    } wave_sel_type;
endpackage
